// [include/tmo_pkg.sv]
// Constants, register map and state types for the I2C time-out monitor.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
package tmo_pkg;

   // Register byte addresses.
   localparam logic [31:0] OFS_TMO_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFS_OWN = 32'h0000_0004;
   localparam logic [31:0] OFS_STAT = 32'h0000_0008;
   localparam logic [31:0] OFS_MODE = 32'h0000_000C;

   // Field positions.
   localparam int TE_BIT = 7;
   localparam int TF_BIT = 6;
   localparam int SEL_MSB = 5;
   localparam int OWN_MSB = 6;
   localparam int MODE_MSB = 7;
   localparam int MODE_EN = 0;
   localparam int STAT_AMF = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_RW = 2;
   localparam int SH_MSB = 7;
   localparam int RW_POS = 0;

   // Reset values.
   localparam logic [7:0] TMO_CTRL_RST = 8'h00;
   localparam logic [6:0] OWN_RST = 7'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [2:0] STAT_RST = 3'h0;
   localparam logic LINE_IDLE = 1'h1;

   // Counting constants.
   localparam logic [4:0] DIV_MAX = 5'h1F;
   localparam logic [4:0] DIV_RST = 5'h00;
   localparam logic [5:0] CNT_RST = 6'h00;
   localparam logic [3:0] ADDR_BITS = 4'h8;
   localparam logic [3:0] BYTE_BITS = 4'h9;
   localparam logic [3:0] BITS_RST = 4'h0;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Front-end bus tracking states.
   typedef enum logic [4:0] {
      FE_IDLE = 5'h01,
      FE_ADDR = 5'h02,
      FE_ACK = 5'h04,
      FE_DATA = 5'h08,
      FE_SKIP = 5'h10
   } fe_state_t;

   // Time-out counter states.
   typedef enum logic [1:0] {
      TM_IDLE = 2'h1,
      TM_RUN = 2'h2
   } tm_state_t;

endpackage

// [include/i2c_evt_if.sv]
// Bundle between the I2C bus front end and the time-out monitor.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface i2c_evt_if;
   logic scl;
   logic sda;
   logic enable;
   logic clear;
   logic hold;
   logic [6:0] own_addr;
   logic scl_fall;
   logic stop;
   logic addr_match;
   logic byte_done;
   logic rw;
   logic busy;
   logic sda_drive;
   logic scl_drive;

   // Front end side.
   modport fe (
      input scl, sda, enable, clear, hold, own_addr,
      output scl_fall, stop, addr_match, byte_done, rw, busy,
      output sda_drive, scl_drive
   );

   // Monitor side.
   modport mon (
      output scl, sda, enable, clear, hold, own_addr,
      input scl_fall, stop, addr_match, byte_done, rw, busy,
      input sda_drive, scl_drive
   );
endinterface

// [core/i2c_front_end.sv]
// I2C slave bus front end: conditions, address match, ack and stretch.
// Assumes SCL and SDA samples are already synchronous to clk.
`timescale 1ns/100ps
module i2c_front_end (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Line samples and events toward the monitor.
   i2c_evt_if.fe bus
);

   logic scl_q;
   logic sda_q;
   logic rise;
   logic start;
   logic kill;
   logic addr_hit;
   logic byte_end;
   logic ack_end;
   logic [3:0] bits_q;
   logic [7:0] shift_q;
   tmo_pkg::fe_state_t st_q;

   // Bus conditions from the previous and current line samples.
   assign bus.scl_fall = scl_q & ~bus.scl;
   assign rise = ~scl_q & bus.scl;
   assign start = scl_q & bus.scl & sda_q & ~bus.sda;
   assign bus.stop = scl_q & bus.scl & ~sda_q & bus.sda;
   assign kill = rst | bus.clear | ~bus.enable;
   assign addr_hit = (st_q == tmo_pkg::FE_ADDR) && bus.scl_fall &&
      (bits_q == tmo_pkg::ADDR_BITS) &&
      (shift_q[tmo_pkg::SH_MSB:tmo_pkg::RW_POS+1] == bus.own_addr);
   assign byte_end = (st_q == tmo_pkg::FE_DATA) && bus.scl_fall &&
      (bits_q == tmo_pkg::BYTE_BITS);
   assign ack_end = (st_q == tmo_pkg::FE_ACK) && bus.scl_fall;

   // Previous line samples; idle lines read high.
   always_ff @(posedge clk) begin
      if (rst) begin
         scl_q <= tmo_pkg::LINE_IDLE;
         sda_q <= tmo_pkg::LINE_IDLE;
      end else begin
         scl_q <= bus.scl;
         sda_q <= bus.sda;
      end
   end

   // Transfer tracking: address shift, bit count and direction.
   always_ff @(posedge clk) begin
      if (kill) begin
         st_q <= tmo_pkg::FE_IDLE;
         bits_q <= tmo_pkg::BITS_RST;
         shift_q <= '0;
         bus.rw <= 1'h0;
         bus.busy <= 1'h0;
      end else if (start) begin
         st_q <= tmo_pkg::FE_ADDR;
         bits_q <= tmo_pkg::BITS_RST;
         bus.busy <= 1'h1;
      end else if (bus.stop) begin
         st_q <= tmo_pkg::FE_IDLE;
         bus.busy <= 1'h0;
      end else begin
         case (st_q)
            tmo_pkg::FE_ADDR: begin
               if (rise) begin
                  shift_q <= {shift_q[tmo_pkg::SH_MSB-1:0], bus.sda};
                  bits_q <= bits_q + 4'h1;
               end else if (bus.scl_fall &&
                            bits_q == tmo_pkg::ADDR_BITS) begin
                  st_q <= addr_hit ? tmo_pkg::FE_ACK : tmo_pkg::FE_SKIP;
                  bus.rw <= shift_q[tmo_pkg::RW_POS];
               end
            end
            tmo_pkg::FE_ACK: begin
               if (ack_end) begin
                  st_q <= tmo_pkg::FE_DATA;
                  bits_q <= tmo_pkg::BITS_RST;
               end
            end
            tmo_pkg::FE_DATA: begin
               if (rise) begin
                  bits_q <= bits_q + 4'h1;
               end else if (byte_end) begin
                  bits_q <= tmo_pkg::BITS_RST;
               end
            end
            tmo_pkg::FE_IDLE, tmo_pkg::FE_SKIP: begin
               st_q <= st_q;
            end
            default: begin
               st_q <= tmo_pkg::FE_IDLE;
            end
         endcase
      end
   end

   // Event pulses, address ack on SDA and clock stretch on SCL.
   always_ff @(posedge clk) begin
      if (kill) begin
         bus.addr_match <= 1'h0;
         bus.byte_done <= 1'h0;
         bus.sda_drive <= 1'h0;
         bus.scl_drive <= 1'h0;
      end else begin
         bus.addr_match <= addr_hit;
         bus.byte_done <= byte_end;
         bus.sda_drive <= addr_hit | (bus.sda_drive & ~ack_end);
         bus.scl_drive <= (ack_end | bus.scl_drive) & bus.hold;
      end
   end

endmodule // i2c_front_end

// [core/i2c_slave_timeout_monitor.sv]
// I2C slave time-out monitor with AXI4-Lite registers.
// Assumes synchronous line samples and a one-cycle subsidiary tick input.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module i2c_slave_timeout_monitor (
   // Clock and reset.
   input wire logic CLK,
   input wire logic RST,
   // Subsidiary clock tick, one cycle per subsidiary period.
   input wire logic SUB_TICK,
   // I2C lines: samples in, open-drain drive out.
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SCL_O,
   output logic SCL_OE,
   output logic SDA_O,
   output logic SDA_OE,
   // Shared serial interrupt request.
   output logic IRQ,
   // AXI4-Lite write address and data.
   input wire logic S_AXI_AWVALID,
   input wire logic [31:0] S_AXI_AWADDR,
   output logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_WREADY,
   // AXI4-Lite write response.
   output logic S_AXI_BVALID,
   output logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read.
   input wire logic S_AXI_ARVALID,
   input wire logic [31:0] S_AXI_ARADDR,
   output logic S_AXI_ARREADY,
   output logic S_AXI_RVALID,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RREADY
);

   i2c_evt_if evt ();

   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic do_wr;
   logic aw_full_d;
   logic w_full_d;
   logic rvalid_d;
   logic aw_full_q;
   logic w_full_q;
   logic [31:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_lo;
   logic wr_ctrl;
   logic wr_own;
   logic wr_stat;
   logic wr_mode;
   logic wr_map;
   logic te_q;
   logic tf_q;
   logic [5:0] sel_q;
   logic [6:0] own_q;
   logic [7:0] mode_q;
   logic amf_q;
   tmo_pkg::tm_state_t tm_q;
   logic running;
   logic [4:0] div_q;
   logic [5:0] cnt_q;
   logic div_tick;
   logic timeout;
   logic [31:0] rd_val;
   logic rd_map;

   ////////////////////////////////////////////////////////////////////////
   // Bus front end.

   i2c_front_end u_fe (
      .clk(CLK),
      .rst(RST),
      .bus(evt)
   );

   // Line samples and controls handed to the front end.
   assign evt.scl = SCL_I;
   assign evt.sda = SDA_I;
   assign evt.own_addr = own_q;
   assign evt.enable = mode_q[tmo_pkg::MODE_EN];
   assign evt.hold = amf_q;
   assign evt.clear = timeout;

   ////////////////////////////////////////////////////////////////////////
   // Time-out counter.

   assign div_tick = SUB_TICK && (div_q == tmo_pkg::DIV_MAX);
   assign running = (tm_q == tmo_pkg::TM_RUN);
   assign timeout = running && te_q && div_tick && (cnt_q == sel_q) &&
      !evt.scl_fall && !evt.stop;

   // Run control: armed by a match, ended by STOP, overflow or disable.
   always_ff @(posedge CLK) begin
      if (RST) begin
         tm_q <= tmo_pkg::TM_IDLE;
      end else begin
         case (tm_q)
            tmo_pkg::TM_IDLE: begin
               if (evt.addr_match && te_q) begin
                  tm_q <= tmo_pkg::TM_RUN;
               end
            end
            tmo_pkg::TM_RUN: begin
               if (timeout || evt.stop || !te_q) begin
                  tm_q <= tmo_pkg::TM_IDLE;
               end
            end
            default: begin
               tm_q <= tmo_pkg::TM_IDLE;
            end
         endcase
      end
   end

   // Prescaler and period count, restarted by each SCL fall.
   always_ff @(posedge CLK) begin
      if (RST || !running || evt.scl_fall) begin
         div_q <= tmo_pkg::DIV_RST;
         cnt_q <= tmo_pkg::CNT_RST;
      end else if (SUB_TICK) begin
         div_q <= div_q + 5'h01;
         if (div_tick) begin
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file.

   // Write strobes per register; only byte lane 0 carries data.
   assign wr_lo = do_wr && wstrb_q[0];
   assign wr_ctrl = wr_lo && (waddr_q == tmo_pkg::OFS_TMO_CTRL);
   assign wr_own = wr_lo && (waddr_q == tmo_pkg::OFS_OWN);
   assign wr_stat = wr_lo && (waddr_q == tmo_pkg::OFS_STAT);
   assign wr_mode = wr_lo && (waddr_q == tmo_pkg::OFS_MODE);
   assign wr_map = (waddr_q == tmo_pkg::OFS_TMO_CTRL) ||
      (waddr_q == tmo_pkg::OFS_OWN) || (waddr_q == tmo_pkg::OFS_STAT) ||
      (waddr_q == tmo_pkg::OFS_MODE);

   // Control register, all zero at reset.
   always_ff @(posedge CLK) begin
      if (RST) begin
         te_q <= tmo_pkg::TMO_CTRL_RST[tmo_pkg::TE_BIT];
         tf_q <= tmo_pkg::TMO_CTRL_RST[tmo_pkg::TF_BIT];
         sel_q <= tmo_pkg::TMO_CTRL_RST[tmo_pkg::SEL_MSB:0];
      end else begin
         if (timeout) begin
            te_q <= 1'h0;
         end else if (wr_ctrl) begin
            te_q <= wdata_q[tmo_pkg::TE_BIT];
         end
         if (timeout) begin
            tf_q <= 1'h1;
         end else if (wr_ctrl) begin
            tf_q <= wdata_q[tmo_pkg::TF_BIT];
         end
         if (wr_ctrl) begin
            sel_q <= wdata_q[tmo_pkg::SEL_MSB:0];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         own_q <= tmo_pkg::OWN_RST;
         mode_q <= tmo_pkg::MODE_RST;
      end else begin
         if (wr_own) begin
            own_q <= wdata_q[tmo_pkg::OWN_MSB:0];
         end
         if (wr_mode) begin
            mode_q <= wdata_q[tmo_pkg::MODE_MSB:0];
         end
      end
   end

   // Status back to reset value on time-out; match set beats clear.
   always_ff @(posedge CLK) begin
      if (RST || timeout) begin
         amf_q <= tmo_pkg::STAT_RST[tmo_pkg::STAT_AMF];
      end else if (evt.addr_match) begin
         amf_q <= 1'h1;
      end else if (wr_stat && wdata_q[tmo_pkg::STAT_AMF]) begin
         amf_q <= 1'h0;
      end
   end

   // Shared interrupt pulse from all three sources.
   always_ff @(posedge CLK) begin
      if (RST) begin
         IRQ <= 1'h0;
      end else begin
         IRQ <= evt.addr_match | evt.byte_done | timeout;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         SCL_O <= 1'h0;
         SDA_O <= 1'h0;
         SCL_OE <= 1'h0;
         SDA_OE <= 1'h0;
      end else begin
         SCL_O <= 1'h0;
         SDA_O <= 1'h0;
         SCL_OE <= evt.scl_drive && !timeout;
         SDA_OE <= evt.sda_drive && !timeout;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave.

   // Handshakes and next occupancy of the holding registers.
   assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
   assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
   assign do_wr = aw_full_q && w_full_q && !S_AXI_BVALID;
   assign aw_full_d = aw_hs || (aw_full_q && !do_wr);
   assign w_full_d = w_hs || (w_full_q && !do_wr);
   assign rvalid_d = ar_hs || (S_AXI_RVALID && !S_AXI_RREADY);

   // Write address and data holding, taken in either order.
   always_ff @(posedge CLK) begin
      if (RST) begin
         aw_full_q <= 1'h0;
         w_full_q <= 1'h0;
         S_AXI_AWREADY <= 1'h0;
         S_AXI_WREADY <= 1'h0;
         waddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         S_AXI_AWREADY <= !aw_full_d;
         S_AXI_WREADY <= !w_full_d;
         if (aw_hs) begin
            waddr_q <= S_AXI_AWADDR;
         end
         if (w_hs) begin
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
         end
      end
   end

   // Write response; unmapped addresses answer SLVERR.
   always_ff @(posedge CLK) begin
      if (RST) begin
         S_AXI_BVALID <= 1'h0;
         S_AXI_BRESP <= tmo_pkg::RESP_OKAY;
      end else if (do_wr) begin
         S_AXI_BVALID <= 1'h1;
         S_AXI_BRESP <= wr_map ? tmo_pkg::RESP_OKAY : tmo_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'h0;
      end
   end

   // Read multiplexer; unused bits read as zero.
   always_comb begin
      rd_val = '0;
      rd_map = 1'h1;
      case (S_AXI_ARADDR)
         tmo_pkg::OFS_TMO_CTRL: begin
            rd_val[tmo_pkg::TE_BIT] = te_q;
            rd_val[tmo_pkg::TF_BIT] = tf_q;
            rd_val[tmo_pkg::SEL_MSB:0] = sel_q;
         end
         tmo_pkg::OFS_OWN: begin
            rd_val[tmo_pkg::OWN_MSB:0] = own_q;
         end
         tmo_pkg::OFS_STAT: begin
            rd_val[tmo_pkg::STAT_AMF] = amf_q;
            rd_val[tmo_pkg::STAT_BUSY] = evt.busy;
            rd_val[tmo_pkg::STAT_RW] = evt.rw;
         end
         tmo_pkg::OFS_MODE: begin
            rd_val[tmo_pkg::MODE_MSB:0] = mode_q;
         end
         default: begin
            rd_map = 1'h0;
         end
      endcase
   end

   // Read channel: one read at a time, data one cycle after the address.
   always_ff @(posedge CLK) begin
      if (RST) begin
         S_AXI_ARREADY <= 1'h0;
         S_AXI_RVALID <= 1'h0;
         S_AXI_RDATA <= '0;
         S_AXI_RRESP <= tmo_pkg::RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !rvalid_d;
         S_AXI_RVALID <= rvalid_d;
         if (ar_hs) begin
            S_AXI_RDATA <= rd_val;
            S_AXI_RRESP <= rd_map ? tmo_pkg::RESP_OKAY : tmo_pkg::RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_run_start;
      @(posedge CLK) disable iff (RST)
      (tm_q == tmo_pkg::TM_IDLE) && evt.addr_match && te_q
      |=> (tm_q == tmo_pkg::TM_RUN);
   endproperty
   a_run_start: assert property (p_run_start)
      else $error("Counter did not start after address match.");

   property p_fall_clear;
      @(posedge CLK) disable iff (RST)
      running && evt.scl_fall |=> (cnt_q == tmo_pkg::CNT_RST) &&
         (div_q == tmo_pkg::DIV_RST);
   endproperty
   a_fall_clear: assert property (p_fall_clear)
      else $error("SCL fall did not clear the counter.");

   property p_expire;
      @(posedge CLK) disable iff (RST)
      running && te_q && div_tick && (cnt_q == sel_q) &&
         !evt.scl_fall && !evt.stop |=> tf_q && !te_q;
   endproperty
   a_expire: assert property (p_expire)
      else $error("Period elapsed without time-out.");

   property p_stop_halt;
      @(posedge CLK) disable iff (RST)
      running && evt.stop |=> !running ##1 !tf_q || $stable(tf_q);
   endproperty
   a_stop_halt: assert property (p_stop_halt)
      else $error("STOP did not halt the counter.");

   property p_ovf_stop;
      @(posedge CLK) disable iff (RST)
      timeout |=> !te_q && !running ##1 (cnt_q == tmo_pkg::CNT_RST);
   endproperty
   a_ovf_stop: assert property (p_ovf_stop)
      else $error("Overflow left counter running or enabled.");

   property p_flag_sticky;
      @(posedge CLK) disable iff (RST)
      tf_q && !wr_ctrl |=> tf_q;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("Time-out flag cleared without a write.");

   property p_irq;
      @(posedge CLK) disable iff (RST)
      $rose(tf_q) && !$past(wr_ctrl) |-> IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("Time-out raised no interrupt.");

   property p_keep_regs;
      @(posedge CLK) disable iff (RST)
      timeout |=> $stable(own_q) && $stable(mode_q);
   endproperty
   a_keep_regs: assert property (p_keep_regs)
      else $error("Time-out altered address or mode register.");

   property p_stat_reset;
      @(posedge CLK) disable iff (RST)
      timeout |=> !amf_q ##1 !evt.busy;
   endproperty
   a_stat_reset: assert property (p_stat_reset)
      else $error("Status not reset by time-out.");

   property p_disabled;
      @(posedge CLK) disable iff (RST)
      !te_q && !wr_ctrl |=> $stable(tf_q) && !running;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("Disabled monitor changed flag or ran.");

   property p_release;
      @(posedge CLK) disable iff (RST)
      timeout |=> !SCL_OE && !SDA_OE ##1 !SCL_OE && !SDA_OE;
   endproperty
   a_release: assert property (p_release)
      else $error("Lines still driven after time-out.");

endmodule // i2c_slave_timeout_monitor

// [verif/i2c_master_model.sv]
// External I2C bus master that drives SCL and SDA.
// Assumes open-drain lines with pull-ups; the slave may stretch SCL.
`timescale 1ns/100ps
module i2c_master_model (
   // Clock.
   input wire logic clk,
   // Slave pull-down enables in, wired lines out.
   input wire logic scl_oe,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   logic scl_drv = 1'b1;
   logic sda_drv = 1'b1;
   // Wired-AND lines; a released line floats high by its pull-up.
   assign scl = scl_drv & ~scl_oe;
   assign sda = sda_drv & ~sda_oe;
   ///////////////////////////////////////////////////////////////////////
   // Half a bit period.
   task automatic half();
      repeat (8) @(posedge clk);
   endtask
   // One bit clock; waits while the slave holds SCL low.
   task automatic clock(input logic b, output logic s);
      sda_drv <= b;
      half();
      scl_drv <= 1'b1;
      while (!scl) @(posedge clk);
      half();
      s = sda;
      scl_drv <= 1'b0;
   endtask
   // START: SDA falls while SCL is high.
   task automatic start();
      sda_drv <= 1'b0;
      half();
      scl_drv <= 1'b0;
   endtask
   // Eight bits MSB first, then the acknowledge clock.
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clock(d[i], s);
      clock(1'b1, ack);
   endtask
   // STOP: SDA rises while SCL is high.
   task automatic stop();
      sda_drv <= 1'b0;
      half();
      scl_drv <= 1'b1;
      half();
      sda_drv <= 1'b1;
      half();
   endtask
endmodule // i2c_master_model

// [verif/testbench.sv]
// Self-checking bench for the I2C slave time-out monitor.
// Assumes SUB_TICK high every cycle, so one tick is one clock.
`timescale 1ns/100ps
module testbench;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic scl, sda, scl_oe, sda_oe, scl_o, sda_o, irq, ack;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int miscompares = 0, checks_done = 0, irqs = 0, base;
   // Clock of 4 ns period.
   always #2 CLK = ~CLK;
   // Counts interrupt pulses.
   always @(posedge CLK) if (irq === 1'b1) irqs++;
   i2c_slave_timeout_monitor i2c_slave_timeout_monitor_i (.CLK(CLK),
      .RST(RST), .SUB_TICK(1'b1), .SCL_I(scl), .SDA_I(sda), .SCL_O(scl_o),
      .SCL_OE(scl_oe), .SDA_O(sda_o), .SDA_OE(sda_oe), .IRQ(irq),
      .S_AXI_AWVALID(awv), .S_AXI_AWADDR(awaddr), .S_AXI_AWREADY(awready),
      .S_AXI_WVALID(wv), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
      .S_AXI_WREADY(wready), .S_AXI_BVALID(bvalid), .S_AXI_BRESP(bresp),
      .S_AXI_BREADY(bready), .S_AXI_ARVALID(arv), .S_AXI_ARADDR(araddr),
      .S_AXI_ARREADY(arready), .S_AXI_RVALID(rvalid), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RREADY(rready));
   i2c_master_model i2c_master_model_i (.clk(CLK), .scl_oe(scl_oe),
      .sda_oe(sda_oe), .scl(scl), .sda(sda));
   ///////////////////////////////////////////////////////////////////////
   // Compares a result and counts it.
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Writes one register and waits for the response.
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge CLK);
      awaddr <= a;
      wdata <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge CLK);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, tmo_pkg::RESP_OKAY);
   endtask
   // Reads one register and compares data and response.
   task automatic rd_chk(input logic [31:0] a, input logic [7:0] d,
      input logic [1:0] r);
      @(posedge CLK);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge CLK);
         if (arready) arv <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk({rresp, rdata}, {r, 24'h0, d});
   endtask
   // Sets the control register, then START and own address.
   task automatic session(input logic [7:0] ctl, input int idle);
      wr(tmo_pkg::OFS_TMO_CTRL, ctl);
      base = irqs;
      i2c_master_model_i.start();
      i2c_master_model_i.send(8'h54, ack);
      repeat (idle) @(posedge CLK);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge CLK);
      miscompares++;
      results();
   end
   ///////////////////////////////////////////////////////////////////////
   // Main sequence of tests.
   initial begin
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      rd_chk(tmo_pkg::OFS_TMO_CTRL, 8'h00, 2'h0);
      rd_chk(32'h0000_0010, 8'h00, tmo_pkg::RESP_SLVERR);
      wr(tmo_pkg::OFS_OWN, 8'h2A);
      wr(tmo_pkg::OFS_MODE, 8'h01);
      // Wrong address: no acknowledge and the counter stays idle.
      wr(tmo_pkg::OFS_TMO_CTRL, 8'h80);
      i2c_master_model_i.start();
      i2c_master_model_i.send(8'h56, ack);
      chk(ack, 1'b1);
      repeat (200) @(posedge CLK);
      i2c_master_model_i.stop();
      rd_chk(tmo_pkg::OFS_TMO_CTRL, 8'h80, 2'h0);
      // Match with the function disabled; stretch lasts past the 32-tick period.
      session(8'h00, 300);
      chk({scl_o, sda_o, scl_oe, sda_oe}, 4'h2);
      rd_chk(tmo_pkg::OFS_TMO_CTRL, 8'h00, 2'h0);
      rd_chk(tmo_pkg::OFS_STAT, 8'h03, 2'h0);
      wr(tmo_pkg::OFS_STAT, 8'h01);
      i2c_master_model_i.send(8'hA5, ack);
      i2c_master_model_i.stop();
      chk(irqs - base, 2);
      // Byte longer than the period, then STOP and a long idle bus.
      session(8'h83, 0);
      chk(ack, 1'b0);
      wr(tmo_pkg::OFS_STAT, 8'h01);
      i2c_master_model_i.send(8'hA5, ack);
      i2c_master_model_i.stop();
      repeat (300) @(posedge CLK);
      rd_chk(tmo_pkg::OFS_TMO_CTRL, 8'h83, 2'h0);
      // Clock stops after the address: time-out after 96 ticks.
      session(8'h82, 90);
      chk(irqs - base, 1);
      repeat (10) @(posedge CLK);
      chk(irqs - base, 2);
      chk({scl_o, sda_o, scl_oe, sda_oe}, 4'h0);
      rd_chk(tmo_pkg::OFS_TMO_CTRL, 8'h42, 2'h0);
      rd_chk(tmo_pkg::OFS_STAT, 8'h00, 2'h0);
      rd_chk(tmo_pkg::OFS_OWN, 8'h2A, 2'h0);
      rd_chk(tmo_pkg::OFS_MODE, 8'h01, 2'h0);
      i2c_master_model_i.stop();
      repeat (100) @(posedge CLK);
      rd_chk(tmo_pkg::OFS_TMO_CTRL, 8'h42, 2'h0);
      wr(tmo_pkg::OFS_TMO_CTRL, 8'h00);
      rd_chk(tmo_pkg::OFS_TMO_CTRL, 8'h00, 2'h0);
      results();
   end
endmodule // testbench
